/* File: wdt_regs.svh */
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// i/o byte addresses
`define WDT_ADDR_W        16
`define WDT_ADDR_FIRST    16'h0067
`define WDT_ADDR_LAST     16'h006D
`define WDT_ADDR_RELOAD   16'h0067
`define WDT_ADDR_ENABLE   16'h0068
`define WDT_ADDR_EVSEL    16'h0069
`define WDT_ADDR_IVL_LO   16'h006A
`define WDT_ADDR_IVL_MID  16'h006B
`define WDT_ADDR_IVL_HI   16'h006C
`define WDT_ADDR_FLAG     16'h006D

// field positions
`define WDT_EN_BIT        6
`define WDT_SEL_MSB       7
`define WDT_SEL_LSB       4
`define WDT_FLAG_BIT      7

// reset values
`define WDT_IVL_RST       24'h00_0000
`define WDT_SEL_RST       4'h0
`define WDT_RDATA_RST     8'h00

// timing
`define WDT_CNT_W         24
`define WDT_CLK_NS        100
`define WDT_TICK_NS       30500
`define WDT_TICK_CYC      (`WDT_TICK_NS / `WDT_CLK_NS)
`define WDT_PHASE_W       9
`define WDT_NUM_IRQ       16

`endif

/* File: wdt_pkg.sv */
package wdt_pkg;

  typedef enum logic [2:0] {
    WDT_IDLE    = 3'b001,
    WDT_RUN     = 3'b010,
    WDT_EXPIRED = 3'b100
  } wdt_state_t;

  typedef enum logic [3:0] {
    WDT_EV_BAD0  = 4'h0,
    WDT_EV_IRQ3  = 4'h1,
    WDT_EV_IRQ4  = 4'h2,
    WDT_EV_IRQ5  = 4'h3,
    WDT_EV_IRQ6  = 4'h4,
    WDT_EV_IRQ7  = 4'h5,
    WDT_EV_IRQ9  = 4'h6,
    WDT_EV_IRQ10 = 4'h7,
    WDT_EV_BAD8  = 4'h8,
    WDT_EV_IRQ12 = 4'h9,
    WDT_EV_IRQ14 = 4'hA,
    WDT_EV_IRQ15 = 4'hB,
    WDT_EV_NMI   = 4'hC,
    WDT_EV_SYSRST = 4'hD,
    WDT_EV_BADE  = 4'hE,
    WDT_EV_BADF  = 4'hF
  } wdt_event_t;

endpackage

/* File: wdt_tick.sv */
`include "wdt_regs.svh"

module wdt_tick (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // control
  input  wire logic restart,
  input  wire logic run,
  // one-cycle tick every 30.5 us
  output logic      tick
);

  localparam logic [`WDT_PHASE_W-1:0] PH_END =
    `WDT_PHASE_W'(`WDT_TICK_CYC - 1);

  logic [`WDT_PHASE_W-1:0] phase_r;
  logic [`WDT_PHASE_W-1:0] phase_nxt;
  logic                    tick_r;
  logic                    tick_nxt;

  always_comb begin
    phase_nxt = phase_r;
    tick_nxt  = 1'b0;
    if (restart) begin
      phase_nxt = '0;
    end else if (run) begin
      tick_nxt  = (phase_r == PH_END);
      phase_nxt = (phase_r == PH_END) ? '0 : phase_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= '0;
      tick_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

/* File: wdt_top.sv */
// How it works
// - 24-bit down counter, one step per 30.5us
// - intervals from one tick to full 2^24
// - registers decoded at i/o 0x67 through 0x6D
// - interval bytes at 0x6A, 0x6B, 0x6C
// - bit 6 of 0x68 enables the timer
// - any write to 0x67 while enabled reloads and restarts
// - expiry while enabled drives selected event
// - select codes map to listed irq lines
// - code C gives nmi, D gives reset
// - timeout flag at 0x6D bit 7, write-one-clear
`include "wdt_regs.svh"

module wdt_top (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // i/o port
  input  wire logic [`WDT_ADDR_W-1:0] io_addr,
  input  wire logic [7:0]             io_wdata,
  input  wire logic                   io_wr,
  input  wire logic                   io_rd,
  output logic      [7:0]             io_rdata,
  // timeout events
  output logic [`WDT_NUM_IRQ-1:0]     irq_out,
  output logic                        nmi_out,
  output logic                        sys_reset_out
);

  localparam logic [`WDT_CNT_W-1:0] CNT_ONE = `WDT_CNT_W'(1);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // select code to one-hot irq number, nmi, reset
  function automatic logic [`WDT_NUM_IRQ+1:0] ev_map(
    input wdt_pkg::wdt_event_t sel
  );
    logic [`WDT_NUM_IRQ+1:0] v;
    v = '0;
    unique case (sel)
      wdt_pkg::WDT_EV_IRQ3:   v[2+3]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ4:   v[2+4]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ5:   v[2+5]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ6:   v[2+6]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ7:   v[2+7]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ9:   v[2+9]  = 1'b1;
      wdt_pkg::WDT_EV_IRQ10:  v[2+10] = 1'b1;
      wdt_pkg::WDT_EV_IRQ12:  v[2+12] = 1'b1;
      wdt_pkg::WDT_EV_IRQ14:  v[2+14] = 1'b1;
      wdt_pkg::WDT_EV_IRQ15:  v[2+15] = 1'b1;
      wdt_pkg::WDT_EV_NMI:    v[1]    = 1'b1;
      wdt_pkg::WDT_EV_SYSRST: v[0]    = 1'b1;
      default:                v       = '0;
    endcase
    return v;
  endfunction

  // register and state
  wdt_pkg::wdt_state_t       state_r,  state_nxt;
  wdt_pkg::wdt_event_t       sel_r,    sel_nxt;
  logic [`WDT_CNT_W-1:0]     ivl_r,    ivl_nxt;
  logic [`WDT_CNT_W-1:0]     cnt_r,    cnt_nxt;
  logic                      en_r,     en_nxt;
  logic                      flag_r,   flag_nxt;
  logic [7:0]                rdata_r,  rdata_nxt;
  logic [`WDT_NUM_IRQ+1:0]   ev_r,     ev_nxt;
  logic                      in_range;
  logic                      wr;
  logic                      start;
  logic                      reload;
  logic                      expire;
  logic                      tick;

  always_comb begin
    in_range = (io_addr >= `WDT_ADDR_FIRST) &&
               (io_addr <= `WDT_ADDR_LAST);
    wr       = io_wr && in_range;
  end

  // register writes
  always_comb begin
    ivl_nxt = ivl_r;
    sel_nxt = sel_r;
    en_nxt  = en_r;
    if (wr) begin
      unique case (io_addr)
        `WDT_ADDR_ENABLE: en_nxt = io_wdata[`WDT_EN_BIT];
        `WDT_ADDR_EVSEL:
          sel_nxt = wdt_pkg::wdt_event_t'(
                      io_wdata[`WDT_SEL_MSB:`WDT_SEL_LSB]);
        `WDT_ADDR_IVL_LO:  ivl_nxt[7:0]   = io_wdata;
        `WDT_ADDR_IVL_MID: ivl_nxt[15:8]  = io_wdata;
        `WDT_ADDR_IVL_HI:  ivl_nxt[23:16] = io_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ivl_r <= `WDT_IVL_RST;
      sel_r <= wdt_pkg::wdt_event_t'(`WDT_SEL_RST);
      en_r  <= 1'b0;
    end else begin
      ivl_r <= ivl_nxt;
      sel_r <= sel_nxt;
      en_r  <= en_nxt;
    end
  end

  wdt_tick u_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .restart (start || reload),
    .run     (state_r == wdt_pkg::WDT_RUN),
    .tick    (tick)
  );

  // countdown; a loaded zero wraps, giving 2^24 ticks
  always_comb begin
    start     = en_nxt && !en_r;
    reload    = wr && (io_addr == `WDT_ADDR_RELOAD) && en_r;
    expire    = 1'b0;
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!en_nxt) begin
      state_nxt = wdt_pkg::WDT_IDLE;
    end else if (start || reload) begin
      state_nxt = wdt_pkg::WDT_RUN;
      cnt_nxt   = ivl_r;
    end else if (state_r == wdt_pkg::WDT_RUN && tick) begin
      cnt_nxt = cnt_r - CNT_ONE;
      if (cnt_r == CNT_ONE) begin
        expire    = 1'b1;
        state_nxt = wdt_pkg::WDT_EXPIRED;
      end
    end
    ev_nxt = (state_nxt == wdt_pkg::WDT_EXPIRED) ? ev_map(sel_r) : '0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= wdt_pkg::WDT_IDLE;
      cnt_r   <= '0;
      ev_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ev_r    <= ev_nxt;
    end
  end

  // timeout flag and read port
  always_comb begin
    flag_nxt = flag_r;
    if (wr && io_addr == `WDT_ADDR_FLAG && io_wdata[`WDT_FLAG_BIT])
      flag_nxt = 1'b0;
    if (expire)
      flag_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if (io_rd) begin
      rdata_nxt = `WDT_RDATA_RST;
      if (io_addr == `WDT_ADDR_FLAG)
        rdata_nxt[`WDT_FLAG_BIT] = flag_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r  <= 1'b0;
      rdata_r <= `WDT_RDATA_RST;
    end else begin
      flag_r  <= flag_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign io_rdata      = rdata_r;
  assign irq_out       = ev_r[`WDT_NUM_IRQ+1:2];
  assign nmi_out       = ev_r[1];
  assign sys_reset_out = ev_r[0];

  // checking helpers
  logic [`WDT_PHASE_W-1:0] gap_r;
  logic [`WDT_PHASE_W-1:0] gap_nxt;
  always_comb begin
    gap_nxt = (&gap_r) ? gap_r : gap_r + 1'b1;
    if (tick)
      gap_nxt = `WDT_PHASE_W'(1);
    if (start || reload)
      gap_nxt = '0;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      gap_r <= '0;
    else
      gap_r <= gap_nxt;
  end

  sequence s_reload_write;
    io_wr && io_addr == `WDT_ADDR_RELOAD && en_r && en_nxt;
  endsequence
  sequence s_last_tick;
    state_r == wdt_pkg::WDT_RUN && en_nxt && !start && !reload &&
    tick && cnt_r == CNT_ONE;
  endsequence

  chk_tick_spacing: assert property (
    tick |-> gap_r == `WDT_PHASE_W'(`WDT_TICK_CYC))
    else $error("tick spacing is not 30.5 us");
  chk_reload_load: assert property (
    s_reload_write |=> cnt_r == $past(ivl_r) &&
                      state_r == wdt_pkg::WDT_RUN)
    else $error("reload write did not reload counter");
  chk_enable_load: assert property (
    $rose(en_r) |-> cnt_r == $past(ivl_r))
    else $error("enable did not load interval");
  chk_disable_quiet: assert property (
    !en_r |-> ev_r == '0 && state_r == wdt_pkg::WDT_IDLE)
    else $error("event active while disabled");
  chk_count_step: assert property (
    state_r == wdt_pkg::WDT_RUN && tick && en_nxt && !start && !reload
    |=> cnt_r == $past(cnt_r) - CNT_ONE)
    else $error("counter did not step down by one");
  chk_expiry_flag: assert property (
    s_last_tick |=> flag_r && state_r == wdt_pkg::WDT_EXPIRED)
    else $error("expiry did not set flag");
  chk_nmi_select: assert property (
    s_last_tick ##0 sel_r == wdt_pkg::WDT_EV_NMI |=> nmi_out && !sys_reset_out)
    else $error("nmi not raised for code C");
  chk_irq3_select: assert property (
    s_last_tick ##0 sel_r == wdt_pkg::WDT_EV_IRQ3 |=> irq_out[3] && !nmi_out)
    else $error("irq3 not raised for code 1");
  chk_flag_clear: assert property (
    io_wr && io_addr == `WDT_ADDR_FLAG && io_wdata[`WDT_FLAG_BIT] && !expire
    |=> !flag_r)
    else $error("flag not cleared by write of one");
  chk_flag_read: assert property (
    io_rd && io_addr == `WDT_ADDR_FLAG |=> io_rdata[7] == $past(flag_r))
    else $error("flag read mismatch");

endmodule

/* File: wdt_sys_model.sv */
`include "wdt_regs.svh"

module wdt_sys_model (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // event lines from the timer
  input  wire logic [`WDT_NUM_IRQ-1:0] irq_in,
  input  wire logic                    nmi_in,
  input  wire logic                    rst_in,
  // count of separate events seen
  output logic      [7:0]              ev_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic any_r;

  // a held level counts once, so a line that chatters shows up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      any_r  <= 1'b0;
      ev_cnt <= 8'h00;
    end else begin
      any_r <= |{irq_in, nmi_in, rst_in};
      if (|{irq_in, nmi_in, rst_in} && !any_r) begin
        ev_cnt <= ev_cnt + 8'h01;
      end
    end
  end
endmodule

/* File: tb_top.sv */
`include "wdt_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                    mclk, rst_n, io_wr, io_rd, nmi_out, sys_reset_out;
  logic [`WDT_ADDR_W-1:0]  io_addr;
  logic [7:0]              io_wdata, io_rdata, ev_cnt;
  logic [`WDT_NUM_IRQ-1:0] irq_out;
  int                      fails = 0;
  int                      num_checks = 0;
  int                      irqn [16] = '{0,3,4,5,6,7,9,10,0,12,14,15,0,0,0,0};

  wdt_top wdt_top_i (.mclk(mclk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
    .irq_out(irq_out), .nmi_out(nmi_out), .sys_reset_out(sys_reset_out));

  wdt_sys_model wdt_sys_model_i (.mclk(mclk), .rst_n(rst_n),
    .irq_in(irq_out), .nmi_in(nmi_out), .rst_in(sys_reset_out),
    .ev_cnt(ev_cnt));

  function automatic logic [17:0] ev_of(input logic [3:0] c);
    ev_of = 18'h0_0000;
    case (c)
      4'hC: ev_of[16] = 1'b1;
      4'hD: ev_of[17] = 1'b1;
      default: if (irqn[c] > 0) ev_of[irqn[c]] = 1'b1;
    endcase
  endfunction

  task automatic summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string       nm,
                     input logic [17:0] e,
                     input logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // one write strobe, taken at the edge on which the task returns
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge mclk);
    io_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge mclk);
    io_rd   <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rdata", {10'h000, e}, {10'h000, io_rdata});
  endtask

  task automatic chk_ev(input string nm, input logic [17:0] e);
    #1;
    chk(nm, e, {sys_reset_out, nmi_out, irq_out});
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #5_000_000;
    fails++;
    summarize();
  end

  initial begin
    rst_n    = 1'b0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = 16'h0000;
    io_wdata = 8'h00;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    chk_ev("reset events", 18'h0_0000);
    rd(`WDT_ADDR_FLAG, 8'h00);
    wr(`WDT_ADDR_IVL_LO, 8'h01);
    wr(`WDT_ADDR_IVL_MID, 8'h00);
    wr(`WDT_ADDR_IVL_HI, 8'h00);
    wr(`WDT_ADDR_EVSEL, 8'h10);
    // enable pattern at an alias outside the window must do nothing
    wr(16'h0168, 8'h40);
    repeat (320) @(posedge mclk);
    chk_ev("alias events", 18'h0_0000);
    rd(`WDT_ADDR_FLAG, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(`WDT_ADDR_EVSEL, {c[3:0], 4'h0});
      wr(`WDT_ADDR_ENABLE, 8'h40);
      repeat (305) @(posedge mclk);
      chk_ev("early", 18'h0_0000);
      @(posedge mclk);
      chk_ev("event", ev_of(c[3:0]));
      rd(`WDT_ADDR_FLAG, 8'h80);
      wr(`WDT_ADDR_FLAG, 8'h80);
      rd(`WDT_ADDR_FLAG, 8'h00);
      chk_ev("held", ev_of(c[3:0]));
      wr(`WDT_ADDR_ENABLE, 8'h00);
      @(posedge mclk);
      chk_ev("disabled", 18'h0_0000);
    end
    chk("pulses", 18'h0_000C, {10'h000, ev_cnt});
    // two ticks, restarted part way through the countdown
    wr(`WDT_ADDR_IVL_LO, 8'h02);
    wr(`WDT_ADDR_EVSEL, 8'h10);
    wr(`WDT_ADDR_ENABLE, 8'h40);
    repeat (400) @(posedge mclk);
    wr(`WDT_ADDR_RELOAD, 8'h5A);
    repeat (610) @(posedge mclk);
    chk_ev("late", 18'h0_0000);
    @(posedge mclk);
    chk_ev("restart", 18'h0_0008);
    wr(`WDT_ADDR_RELOAD, 8'hA5);
    @(posedge mclk);
    chk_ev("reloaded", 18'h0_0000);
    wr(`WDT_ADDR_ENABLE, 8'h00);
    wr(`WDT_ADDR_RELOAD, 8'h00);
    repeat (700) @(posedge mclk);
    chk_ev("stopped", 18'h0_0000);
    // reset in mid-count: timer off, flag (still set) cleared, no event
    wr(`WDT_ADDR_ENABLE, 8'h40);
    repeat (100) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (700) @(posedge mclk);
    chk_ev("reset mid", 18'h0_0000);
    rd(`WDT_ADDR_FLAG, 8'h00);
    summarize();
  end
endmodule
